// ==== eesa_map.svh ====
// Summary of operation
// RQ1: master opens every transaction with start
// RQ2: addressed receiver acknowledges each received byte
// RQ3: missing acknowledge ends the transmitter's sending; this slave never transmits, read data lies outside this block
// RQ4: master closes transaction with a stop
// RQ5: master sends type, select, direction, address
// RQ6: first byte: type, select, direction fields
// RQ7: device type mismatch ignores the transaction
// RQ8: select bits must equal strapped pins
// RQ9: one 256-byte block, selects are chip selects
// RQ10: direction bit one reads, zero writes
// RQ11: receiver holds data low through ninth clock
// RQ12: byte after address is array address
// RQ13: silent during program cycle after write stop
// RQ14: suppress glitches shorter than filter time
// RQ15: start is data falling with clock high
// RQ16: stop is data rising with clock high
// RQ17: data changes only while clock low
// RQ18: after program cycle, answer again normally
// RQ19: address mismatch keeps data released until start
`ifndef EESA_MAP_SVH
`define EESA_MAP_SVH
`define EESA_CLK_PERIOD_PS   25000
`define EESA_GLITCH_NS       100
`define EESA_GLITCH_CYC      ((`EESA_GLITCH_NS * 1000 + \
                               `EESA_CLK_PERIOD_PS - 1) / \
                              `EESA_CLK_PERIOD_PS)
`define EESA_TWR_MS          10
// worked in ns so the product stays inside 32 bits
`define EESA_TWR_CYC         ((`EESA_TWR_MS * 1000000) / \
                              (`EESA_CLK_PERIOD_PS / 1000))
`define EESA_DEV_TYPE        4'ha
`define EESA_TYPE_HI         7
`define EESA_TYPE_LO         4
`define EESA_SEL_HI          3
`define EESA_SEL_LO          1
`define EESA_RW_BIT          0
`define EESA_BLOCK_BYTES     256
`endif

// ==== eesa_pkg.sv ====
package eesa_pkg;
   typedef enum logic [2:0] {
      EESA_IDLE,
      EESA_SLAVE_ADDR,
      EESA_ACK_SLAVE,
      EESA_ARRAY_ADDR,
      EESA_ACK_ARRAY,
      EESA_DATA,
      EESA_IGNORE
   } eesa_state_t;
endpackage

// ==== eesa_filter.sv ====
`timescale 1ns/1ps
`include "eesa_map.svh"
// two-flop synchroniser followed by a stability filter
module eesa_filter (
   input  wire logic clk,    // system clock
   input  wire logic rst_n,  // async reset, active low
   input  wire logic pin,    // raw line level
   output logic      level   // filtered line level
);
   localparam logic [3:0] GLITCH = 4'(`EESA_GLITCH_CYC);
   logic       sync1;
   logic       sync2;
   logic [3:0] count;
   logic [3:0] next_count;
   logic       next_level;

   // a level must hold GLITCH cycles before it is believed
   always_comb begin
      next_count = count;
      next_level = level;
      if (sync2 == level) begin
         next_count = 4'h0;
      end else if (count >= GLITCH - 4'h1) begin // see RQ14
         next_level = sync2;
         next_count = 4'h0;
      end else begin
         next_count = count + 4'h1;
      end
   end

   // idle bus level is high, so reset to one
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1 <= 1'b1;
         sync2 <= 1'b1;
         count <= 4'h0;
         level <= 1'b1;
      end else begin
         sync1 <= pin;
         sync2 <= sync1;
         count <= next_count;
         level <= next_level;
      end
   end

   short_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
      $changed(level) |-> $past(sync2, 1) == level
         && $past(sync2, 4) == level) // see RQ14
      else $error("filter passed a short pulse");
endmodule // eesa_filter

// ==== eesa_slave.sv ====
`timescale 1ns/1ps
`include "eesa_map.svh"
module eesa_slave #(
   parameter int unsigned TWR_CYC = `EESA_TWR_CYC // program cycle length
) (
   input  wire logic       clk,                // 40 MHz system clock
   input  wire logic       rst_n,              // async reset, active low
   input  wire logic       scl_in,             // serial clock pin
   input  wire logic       sda_in,             // serial data pin level
   output logic            sda_out,            // data drive value
   output logic            sda_oe,             // high while pulling low
   input  wire logic [2:0] chip_select_straps, // strapped select pins
   output logic [7:0]      array_addr,         // last array address
   output logic            addr_valid,         // array address taken
   output logic            read_req,           // direction flag seen
   output logic            write_busy          // program cycle running
);
   import eesa_pkg::*;

   logic        scl_f;
   logic        sda_f;
   logic        scl_d;
   logic        sda_d;
   eesa_state_t state;
   eesa_state_t next_state;
   logic [3:0]  bit_cnt;
   logic [3:0]  next_bit_cnt;
   logic [7:0]  shift;
   logic [7:0]  next_shift;
   logic [7:0]  next_array_addr;
   logic        next_addr_valid;
   logic        next_read_req;
   logic        wrote;
   logic        next_wrote;
   logic [31:0] twr_cnt;
   logic [31:0] next_twr_cnt;
   logic        next_write_busy;
   logic        next_sda_oe;

   eesa_filter u_scl (
      .clk   (clk),
      .rst_n (rst_n),
      .pin   (scl_in),
      .level (scl_f)
   );
   eesa_filter u_sda (
      .clk   (clk),
      .rst_n (rst_n),
      .pin   (sda_in),
      .level (sda_f)
   );

   // bus events from filtered levels
   wire scl_rise = scl_f && !scl_d;
   wire scl_fall = !scl_f && scl_d;
   wire start_ev = scl_f && scl_d && sda_d && !sda_f; // see RQ15
   wire stop_ev  = scl_f && scl_d && !sda_d && sda_f; // see RQ16

   // slave address match on the byte complete at the eighth rise
   function automatic logic addr_match(input logic [7:0] b,
                                       input logic [2:0] straps);
      addr_match = (b[`EESA_TYPE_HI:`EESA_TYPE_LO] == `EESA_DEV_TYPE)
         && (b[`EESA_SEL_HI:`EESA_SEL_LO] == straps); // see RQ7 RQ8
   endfunction

   // protocol sequencer; a busy program cycle keeps it idle
   always_comb begin
      next_state      = state;
      next_bit_cnt    = bit_cnt;
      next_shift      = shift;
      next_array_addr = array_addr;
      next_addr_valid = 1'b0;
      next_read_req   = read_req;
      next_wrote      = wrote;
      next_twr_cnt    = twr_cnt;
      next_write_busy = write_busy;
      next_sda_oe     = sda_oe;
      if (write_busy) begin
         // interface disabled, line released; see RQ13
         next_state  = EESA_IDLE;
         next_sda_oe = 1'b0;
         if (twr_cnt == 32'h0) begin
            next_write_busy = 1'b0; // see RQ18
         end else begin
            next_twr_cnt = twr_cnt - 32'h1;
         end
      end else if (start_ev) begin
         next_state   = EESA_SLAVE_ADDR; // see RQ15
         next_bit_cnt = 4'h0;
         next_wrote   = 1'b0;
         next_sda_oe  = 1'b0;
      end else if (stop_ev) begin
         next_state  = EESA_IDLE; // see RQ16
         next_sda_oe = 1'b0;
         if (wrote) begin
            // program cycle starts at a stop ending a write; see RQ13
            next_write_busy = 1'b1;
            next_twr_cnt    = 32'(TWR_CYC - 1);
            next_wrote      = 1'b0;
         end
      end else begin
         case (state)
            EESA_SLAVE_ADDR, EESA_ARRAY_ADDR, EESA_DATA: begin
               // bits sampled on the rise, stable while high; see RQ17
               if (scl_rise) begin
                  next_shift   = {shift[6:0], sda_f};
                  next_bit_cnt = bit_cnt + 4'h1;
               end
               if (scl_fall && bit_cnt == 4'h8) begin
                  next_bit_cnt = 4'h0;
                  if (state == EESA_SLAVE_ADDR) begin
                     // see RQ6 RQ9 RQ10
                     next_read_req = shift[`EESA_RW_BIT];
                     if (addr_match(shift, chip_select_straps)) begin
                        next_state  = EESA_ACK_SLAVE;
                        next_sda_oe = 1'b1; // see RQ2 RQ11
                     end else begin
                        next_state = EESA_IGNORE; // see RQ19
                     end
                  end else if (state == EESA_ARRAY_ADDR) begin
                     next_array_addr = shift; // see RQ12
                     next_addr_valid = 1'b1;
                     next_state      = EESA_ACK_ARRAY;
                     next_sda_oe     = 1'b1; // see RQ11
                  end else begin
                     next_wrote  = 1'b1;
                     next_state  = EESA_ACK_ARRAY;
                     next_sda_oe = 1'b1; // see RQ2
                  end
               end
            end
            EESA_ACK_SLAVE, EESA_ACK_ARRAY: begin
               // release after the ninth clock falls; see RQ11
               if (scl_fall) begin
                  next_sda_oe = 1'b0;
                  if (state == EESA_ACK_SLAVE && !read_req) begin
                     next_state = EESA_ARRAY_ADDR;
                  end else if (state == EESA_ACK_ARRAY) begin
                     next_state = EESA_DATA;
                  end else begin
                     // read data path lies outside this block; see RQ3
                     next_state = EESA_IGNORE;
                  end
               end
            end
            EESA_IGNORE: begin
               next_sda_oe = 1'b0; // see RQ19
            end
            default: begin
               next_state = EESA_IDLE; // see RQ1
            end
         endcase
      end
   end

   // registers; every output except the constant sda_out comes straight from flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_d      <= 1'b1;
         sda_d      <= 1'b1;
         state      <= EESA_IDLE;
         bit_cnt    <= 4'h0;
         shift      <= 8'h00;
         array_addr <= 8'h00;
         addr_valid <= 1'b0;
         read_req   <= 1'b0;
         wrote      <= 1'b0;
         twr_cnt    <= 32'h0;
         write_busy <= 1'b0;
         sda_oe     <= 1'b0;
      end else begin
         scl_d      <= scl_f;
         sda_d      <= sda_f;
         state      <= next_state;
         bit_cnt    <= next_bit_cnt;
         shift      <= next_shift;
         array_addr <= next_array_addr;
         addr_valid <= next_addr_valid;
         read_req   <= next_read_req;
         wrote      <= next_wrote;
         twr_cnt    <= next_twr_cnt;
         write_busy <= next_write_busy;
         sda_oe     <= next_sda_oe;
      end
   end

   // open drain: only ever drives low
   assign sda_out = 1'b0;

   busy_silent_a: assert property (@(posedge clk) disable iff (!rst_n)
      write_busy |=> !sda_oe) // see RQ13
      else $error("data driven during program cycle");
   ignore_silent_a: assert property (@(posedge clk) disable iff (!rst_n)
      state == EESA_IGNORE |-> !sda_oe) // see RQ19
      else $error("data driven after address mismatch");
   ack_match_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(sda_oe) && $past(state) == EESA_SLAVE_ADDR
         |-> $past(shift[7:4]) == `EESA_DEV_TYPE
          && $past(shift[3:1]) == chip_select_straps) // see RQ7 RQ8
      else $error("acknowledged a foreign address");
   ack_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(sda_oe) |=> sda_oe [*2]) // see RQ11
      else $error("acknowledge dropped too early");
   ack_release_a: assert property (@(posedge clk) disable iff (!rst_n)
      (state == EESA_ACK_SLAVE || state == EESA_ACK_ARRAY) && scl_fall
         && !write_busy && !start_ev && !stop_ev |=> !sda_oe) // see RQ11
      else $error("acknowledge not released");
   start_seen_a: assert property (@(posedge clk) disable iff (!rst_n)
      start_ev && !write_busy |=> state == EESA_SLAVE_ADDR
         && bit_cnt == 4'h0) // see RQ15
      else $error("start not recognised");
   stop_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
      stop_ev && !write_busy |=> state == EESA_IDLE) // see RQ16
      else $error("stop not recognised");
   busy_begin_a: assert property (@(posedge clk) disable iff (!rst_n)
      stop_ev && wrote && !write_busy |=> write_busy) // see RQ13
      else $error("program cycle not started");
   addr_take_a: assert property (@(posedge clk) disable iff (!rst_n)
      addr_valid |-> state == EESA_ACK_ARRAY
         && array_addr == $past(shift)) // see RQ12
      else $error("array address wrong");
endmodule // eesa_slave

// ==== eesa_master.sv ====
`timescale 1ns/1ps
// bus master model; scl rests high between frames, 200 ns bit period
module eesa_master (
   input  wire logic clk,   // system clock
   input  wire logic sda,   // resolved data line
   output logic      scl,   // serial clock drive
   output logic      sda_o  // data drive, 1 releases to pull-up
);
   initial begin
      scl   = 1'b1;
      sda_o = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // data falls while clock high opens a frame
   task automatic start_cond();
      sda_o <= 1'b0;
      tick(4);
      scl <= 1'b0;
      tick(2);
   endtask
   // data rises while clock high closes it
   task automatic stop_cond();
      sda_o <= 1'b0;
      tick(2);
      scl <= 1'b1;
      tick(4);
      sda_o <= 1'b1;
      tick(8);
   endtask
   // 50 ns dip with clock high, then clocks as if a frame had opened
   task automatic glitch();
      sda_o <= 1'b0;
      tick(2);
      sda_o <= 1'b1;
      tick(4);
      scl <= 1'b0;
      tick(2);
   endtask
   // msb first; ack sampled late in the ninth high, where it settles
   task automatic send_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sda_o <= b[i];
         tick(2);
         scl <= 1'b1;
         tick(4);
         scl <= 1'b0;
         tick(2);
      end
      sda_o <= 1'b1;
      // slave pulls low about 7 clocks after our fall through its
      // filters, so the low phases around the ninth clock are stretched
      tick(8);
      scl <= 1'b1;
      tick(3);
      @(negedge clk);
      ack = sda;
      tick(1);
      scl <= 1'b0;
      tick(10);
   endtask
endmodule // eesa_master

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
   localparam int unsigned TWR = 200; // shortened program cycle
   logic       clk;
   logic       rst_n;
   logic       scl;
   logic       m_sda;
   logic       sda;
   logic       sda_out;
   logic       sda_oe;
   logic [2:0] straps;
   logic [7:0] array_addr;
   logic       addr_valid;
   logic       read_req;
   logic       write_busy;
   int         mismatches;
   int         checked;
   int         pulses;
   int         busy_cyc;
   // open drain with pull-up
   assign sda = m_sda & (sda_oe ? sda_out : 1'b1);
   eesa_master m (.clk(clk), .sda(sda), .scl(scl), .sda_o(m_sda));
   eesa_slave #(.TWR_CYC(TWR)) dut (
      .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_straps(straps),
      .array_addr(array_addr), .addr_valid(addr_valid),
      .read_req(read_req), .write_busy(write_busy));
   always #12.5 clk = ~clk;
   // strobe count and program cycle length
   always @(posedge clk) begin
      if (addr_valid === 1'b1) pulses++;
      if (write_busy === 1'b1) busy_cyc++;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("mismatches %0d checked %0d", mismatches, checked);
      if (mismatches == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // selected write, silence while programming, then answers again
   task automatic t_write();
      logic ack;
      int   p0;
      p0 = pulses;
      m.start_cond();
      m.send_byte({4'ha, straps, 1'b0}, ack);
      check(ack, 0);
      m.send_byte(8'hc5, ack);
      check(ack, 0);
      check(array_addr, 8'hc5);
      check(8'(pulses - p0), 1);
      check(read_req, 0);
      m.send_byte(8'h3e, ack);
      check(ack, 0);
      busy_cyc = 0;
      m.stop_cond();
      check(write_busy, 1);
      m.start_cond();
      m.send_byte({4'ha, straps, 1'b0}, ack);
      check(ack, 1);
      m.stop_cond();
      for (int i = 0; i < 2 * TWR && write_busy === 1'b1; i++)
         m.tick(1);
      check(8'(busy_cyc), 8'(TWR));
      m.start_cond();
      m.send_byte({4'ha, straps, 1'b0}, ack);
      check(ack, 0);
      m.stop_cond();
   endtask
   // each select bit flipped, then a wrong type: line stays released
   task automatic t_refuse();
      logic ack;
      for (int k = 0; k < 4; k++) begin
         m.start_cond();
         m.send_byte(k == 3 ? {4'hb, straps, 1'b0} :
                     {4'ha, straps ^ 3'(1 << k), 1'b0}, ack);
         check(ack, 1);
         m.send_byte(8'h00, ack);
         check(ack, 1);
         m.stop_cond();
      end
   endtask
   task automatic t_read();
      logic ack;
      m.start_cond();
      m.send_byte({4'ha, straps, 1'b1}, ack);
      check(ack, 0);
      check(read_req, 1);
      m.stop_cond();
   endtask
   // reset in mid-frame clears outputs; bus works again afterwards
   task automatic t_reset();
      logic ack;
      m.start_cond();
      m.send_byte({4'ha, straps, 1'b0}, ack);
      check(ack, 0);
      m.send_byte(8'h5a, ack);
      check(array_addr, 8'h5a);
      rst_n <= 1'b0;
      m.tick(2);
      check({sda_oe, write_busy, addr_valid, read_req}, 0);
      check(array_addr, 0);
      rst_n <= 1'b1;
      m.tick(10);
      m.stop_cond();
      m.start_cond();
      m.send_byte({4'ha, straps, 1'b0}, ack);
      check(ack, 0);
      m.stop_cond();
   endtask
   // a filtered-out dip must not open a frame
   task automatic t_glitch();
      logic ack;
      m.glitch();
      m.send_byte({4'ha, straps, 1'b0}, ack);
      check(ack, 1);
      m.stop_cond();
   endtask
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      straps = 3'b101;
      mismatches = 0;
      checked = 0;
      pulses = 0;
      busy_cyc = 0;
      m.tick(6);
      check({sda_oe, write_busy, addr_valid, read_req}, 0);
      check(array_addr, 0);
      rst_n <= 1'b1;
      m.tick(10);
      t_write();
      t_refuse();
      straps <= 3'b010;
      m.tick(2);
      t_read();
      straps <= 3'b011;
      m.tick(2);
      t_glitch();
      t_reset();
      summarize();
   end
   // watchdog, well past the few thousand cycles the run needs
   initial begin
      m.tick(20000);
      mismatches++;
      summarize();
   end
endmodule // testbench
